// [hw/afe_regs.vh]
// register selects, field positions and power-up values of the afe control bank
`ifndef AFE_REGS_VH
`define AFE_REGS_VH
`define AFE_SEL_RED_GAIN 3'h0
`define AFE_SEL_RED_OFS 3'h1
`define AFE_SEL_GRN_GAIN 3'h2
`define AFE_SEL_GRN_OFS 3'h3
`define AFE_SEL_BLU_GAIN 3'h4
`define AFE_SEL_BLU_OFS 3'h5
`define AFE_SEL_MODE 3'h6
`define AFE_SEL_MODE_TEST 3'h7
`define AFE_GAIN_RST 8'h00
`define AFE_OFS_RST 8'h40
`define AFE_MODE_RST 8'h00
`define AFE_MTEST_RST 8'h00
`define AFE_MODE_PDN 7
`define AFE_MODE_SRST 6
`define AFE_MODE_VRT 5
`define AFE_MODE_DCREF 4
`define AFE_MODE_AC 3
`define AFE_MODE_POL 2
`define AFE_MT_T5 7
`define AFE_MT_ODIS 6
`define AFE_MT_DACR 5
`define AFE_MT_CISREF 4
`define AFE_MT_T4 3
`define AFE_MT_T3 2
`define AFE_MT_T2 1
`define AFE_MT_T1 0
`define AFE_WORD_BITS 11
`define AFE_CFG_RED 2'h1
`endif

// [hw/afe_serial_rx.v]
// serial word receiver: shifts 11 bits while load is low, pulses on load rise
`timescale 1ns/1ps
module afe_serial_rx (
  input wire CLK_SYS,
  input wire RST_N,
  input wire SCLK,
  input wire SDATA,
  input wire LOAD,
  output reg WR_STB,
  output reg [2:0] WR_SEL,
  output reg [7:0] WR_DATA
);
`include "afe_regs.vh"
  reg sclk_q;
  reg load_q;
  reg [10:0] shift_q;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sclk_q <= 1'b0;
      load_q <= 1'b1;
      shift_q <= 11'h000;
      WR_STB <= 1'b0;
      WR_SEL <= 3'h0;
      WR_DATA <= 8'h00;
    end else begin
      sclk_q <= SCLK;
      load_q <= LOAD;
      WR_STB <= 1'b0;
      // msb first, so after 11 bits the select sits on top
      if (!LOAD && SCLK && !sclk_q) begin
        shift_q <= {shift_q[9:0], SDATA};
      end
      if (LOAD && !load_q) begin
        WR_STB <= 1'b1;
        WR_SEL <= shift_q[10:8];
        WR_DATA <= shift_q[7:0];
      end
    end
  end
endmodule // afe_serial_rx

// [hw/afe_ctrl_bank.v]
// afe control register bank: serial load, mode and mode/test decode
`timescale 1ns/1ps
// How it works
// - mode bit 7 high puts logic into power-down, low is normal.
// - writing soft reset bit as 1 restores every register's power-up value.
// - top reference: 0 internal, 1 external.
// - dc reference: 0 analog ground, 1 external dc reference pin.
// - polarity: 0 non-inverted, 1 inverted input.
// - config 01 red only; 10 and 11 cycle red, green, blue.
// - offset dac range: 0 gives -200..+600mV, 1 gives -400..+400mV.
// - contact sensor reference circuit enabled when its bit is 1.
// - test bit four ties buffer output to blue input.
// - test bit three ties amplifier output to external dc pin.
// - test bit two ties converter input to green input.
// - serial word: three select bits then eight data bits.
module afe_ctrl_bank (
  input wire CLK_SYS,
  input wire RST_N,
  input wire SCLK,
  input wire SDATA,
  input wire LOAD,
  output reg [5:0] RED_GAIN,
  output reg [5:0] GRN_GAIN,
  output reg [5:0] BLU_GAIN,
  output reg [7:0] RED_OFFSET,
  output reg [7:0] GRN_OFFSET,
  output reg [7:0] BLU_OFFSET,
  output reg POWER_DOWN,
  output reg TOP_REFERENCE_SELECT,
  output reg INPUT_DC_REFERENCE,
  output reg AC_COUPLED,
  output reg INVERTED_POLARITY,
  output reg [1:0] SIGNAL_CONFIG,
  output reg TRIPLE_CHANNEL,
  output reg OFFSET_RANGE_SYM,
  output reg CIS_REFERENCE_EN,
  output reg BUFFER_TO_BLUE_TEST,
  output reg AMP_TO_EXTREF_TEST,
  output reg CONVERTER_FROM_GREEN_TEST,
  output reg FIRST_TEST_ENABLE,
  output reg RESERVED_TEST_BIT_HIGH,
  output reg DATA_OUT_EN
);
`include "afe_regs.vh"
  wire wr_stb;
  wire [2:0] wr_sel;
  wire [7:0] wr_data;
  reg [7:0] mode_q;
  reg [7:0] mtest_q;
  reg [7:0] gain_q [0:2];
  reg [7:0] ofs_q [0:2];
  integer i;

  afe_serial_rx u_rx (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .SCLK(SCLK),
    .SDATA(SDATA),
    .LOAD(LOAD),
    .WR_STB(wr_stb),
    .WR_SEL(wr_sel),
    .WR_DATA(wr_data)
  );

  // register kinds reached by the three select bits
  localparam KIND_GAIN = 2'h0;
  localparam KIND_OFS = 2'h1;
  localparam KIND_MODE = 2'h2;
  localparam KIND_MTEST = 2'h3;

  // the two mode words sit on top, gains even and offsets odd below
  function [1:0] sel_kind;
    input [2:0] sel;
    begin
      if (sel == `AFE_SEL_MODE) begin
        sel_kind = KIND_MODE;
      end else if (sel == `AFE_SEL_MODE_TEST) begin
        sel_kind = KIND_MTEST;
      end else if (sel[0]) begin
        sel_kind = KIND_OFS;
      end else begin
        sel_kind = KIND_GAIN;
      end
    end
  endfunction

  function sel_is_mode;
    input [2:0] sel;
    begin
      sel_is_mode = (sel_kind(sel) == KIND_MODE);
    end
  endfunction

  function sel_is_mtest;
    input [2:0] sel;
    begin
      sel_is_mtest = (sel_kind(sel) == KIND_MTEST);
    end
  endfunction

  function sel_is_ofs;
    input [2:0] sel;
    begin
      sel_is_ofs = (sel_kind(sel) == KIND_OFS);
    end
  endfunction

  function sel_is_gain;
    input [2:0] sel;
    begin
      sel_is_gain = (sel_kind(sel) == KIND_GAIN);
    end
  endfunction

  // the upper two select bits name the colour channel
  function sel_hits_chan;
    input [2:0] sel;
    input [1:0] chan;
    begin
      sel_hits_chan = (sel[2:1] == chan);
    end
  endfunction

  // power-down loses coupling and channel sequencing, keeps the rest
  function [7:0] mode_filter;
    input [7:0] word;
    begin
      mode_filter = word;
      if (word[`AFE_MODE_PDN]) begin
        mode_filter[`AFE_MODE_AC] = 1'b0;
        mode_filter[1:0] = 2'b00;
      end
    end
  endfunction

  // gain words carry six bits on top, the low two are unused
  function [5:0] gain_field;
    input [7:0] word;
    begin
      gain_field = word[7:2];
    end
  endfunction

  // codes 10 and 11 both run the three-colour sequence
  function cfg_is_triple;
    input [1:0] cfg;
    begin
      cfg_is_triple = cfg[1];
    end
  endfunction

  // drivers also off in power-down
  function drivers_on;
    input [7:0] mode;
    input [7:0] mtest;
    begin
      drivers_on = !mtest[`AFE_MT_ODIS] &&
        !mode[`AFE_MODE_PDN];
    end
  endfunction

  // one-cycle write enables per register kind
  wire soft_rst;
  assign soft_rst = wr_stb && sel_is_mode(wr_sel) &&
    wr_data[`AFE_MODE_SRST];
  wire mode_wr;
  assign mode_wr = wr_stb && sel_is_mode(wr_sel);
  wire mtest_wr;
  assign mtest_wr = wr_stb && sel_is_mtest(wr_sel);
  wire ofs_wr;
  assign ofs_wr = wr_stb && sel_is_ofs(wr_sel);
  wire gain_wr;
  assign gain_wr = wr_stb && sel_is_gain(wr_sel);
  reg [7:0] mode_d;
  reg [7:0] mtest_d;
  // next values of the control outputs
  reg pdn_d;
  reg vrt_d;
  reg dcref_d;
  reg ac_d;
  reg pol_d;
  reg [1:0] cfg_d;
  reg triple_d;
  reg dacr_d;
  reg cisref_d;
  reg blue_test_d;
  reg extref_test_d;
  reg green_test_d;
  reg first_test_d;
  reg rsv_test_d;
  reg oe_d;

  // soft reset word itself is not stored: all go to power-up values
  always @* begin
    mode_d = mode_q;
    mtest_d = mtest_q;
    if (soft_rst) begin
      mode_d = `AFE_MODE_RST;
      mtest_d = `AFE_MTEST_RST;
    end else if (mode_wr) begin
      mode_d = mode_filter(wr_data);
    end else if (mtest_wr) begin
      mtest_d = wr_data;
    end
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mode_q <= `AFE_MODE_RST;
      mtest_q <= `AFE_MTEST_RST;
    end else begin
      mode_q <= mode_d;
      mtest_q <= mtest_d;
    end
  end

  // gain and offset words, one of each per colour channel
  always @(posedge CLK_SYS) begin
    if (!RST_N || soft_rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        gain_q[i] <= `AFE_GAIN_RST;
        ofs_q[i] <= `AFE_OFS_RST;
      end
    end else if (ofs_wr) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (sel_hits_chan(wr_sel, i[1:0])) begin
          ofs_q[i] <= wr_data;
        end
      end
    end else if (gain_wr) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (sel_hits_chan(wr_sel, i[1:0])) begin
          gain_q[i] <= wr_data;
        end
      end
    end
  end

  always @* begin
    pdn_d = mode_q[`AFE_MODE_PDN];
    vrt_d = mode_q[`AFE_MODE_VRT];
    dcref_d = mode_q[`AFE_MODE_DCREF];
    ac_d = mode_q[`AFE_MODE_AC];
    pol_d = mode_q[`AFE_MODE_POL];
    cfg_d = mode_q[1:0];
    triple_d = cfg_is_triple(mode_q[1:0]);
    dacr_d = mtest_q[`AFE_MT_DACR];
    cisref_d = mtest_q[`AFE_MT_CISREF];
    blue_test_d = mtest_q[`AFE_MT_T4];
    extref_test_d = mtest_q[`AFE_MT_T3];
    green_test_d = mtest_q[`AFE_MT_T2];
    first_test_d = mtest_q[`AFE_MT_T1];
    rsv_test_d = mtest_q[`AFE_MT_T5];
    oe_d = drivers_on(mode_q, mtest_q);
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RED_GAIN <= 6'h00;
      GRN_GAIN <= 6'h00;
      BLU_GAIN <= 6'h00;
      RED_OFFSET <= `AFE_OFS_RST;
      GRN_OFFSET <= `AFE_OFS_RST;
      BLU_OFFSET <= `AFE_OFS_RST;
      POWER_DOWN <= 1'b0;
      TOP_REFERENCE_SELECT <= 1'b0;
      INPUT_DC_REFERENCE <= 1'b0;
      AC_COUPLED <= 1'b0;
      INVERTED_POLARITY <= 1'b0;
      SIGNAL_CONFIG <= 2'h0;
      TRIPLE_CHANNEL <= 1'b0;
      OFFSET_RANGE_SYM <= 1'b0;
      CIS_REFERENCE_EN <= 1'b0;
      BUFFER_TO_BLUE_TEST <= 1'b0;
      AMP_TO_EXTREF_TEST <= 1'b0;
      CONVERTER_FROM_GREEN_TEST <= 1'b0;
      FIRST_TEST_ENABLE <= 1'b0;
      RESERVED_TEST_BIT_HIGH <= 1'b0;
      DATA_OUT_EN <= 1'b0;
    end else begin
      // every output is a flip-flop loaded from its next value
      RED_GAIN <= gain_field(gain_q[0]);
      GRN_GAIN <= gain_field(gain_q[1]);
      BLU_GAIN <= gain_field(gain_q[2]);
      RED_OFFSET <= ofs_q[0];
      GRN_OFFSET <= ofs_q[1];
      BLU_OFFSET <= ofs_q[2];
      POWER_DOWN <= pdn_d;
      TOP_REFERENCE_SELECT <= vrt_d;
      INPUT_DC_REFERENCE <= dcref_d;
      AC_COUPLED <= ac_d;
      INVERTED_POLARITY <= pol_d;
      SIGNAL_CONFIG <= cfg_d;
      TRIPLE_CHANNEL <= triple_d;
      OFFSET_RANGE_SYM <= dacr_d;
      CIS_REFERENCE_EN <= cisref_d;
      BUFFER_TO_BLUE_TEST <= blue_test_d;
      AMP_TO_EXTREF_TEST <= extref_test_d;
      CONVERTER_FROM_GREEN_TEST <= green_test_d;
      FIRST_TEST_ENABLE <= first_test_d;
      RESERVED_TEST_BIT_HIGH <= rsv_test_d;
      DATA_OUT_EN <= oe_d;
    end
  end
endmodule // afe_ctrl_bank

// [bench/afe_ctrl_bank_properties.sv]
// port assertions for the afe control bank
`timescale 1ns/1ps
module afe_ctrl_bank_properties (
  input wire CLK_SYS,
  input wire RST_N,
  input wire SCLK,
  input wire SDATA,
  input wire LOAD,
  input wire [5:0] RED_GAIN,
  input wire [7:0] BLU_OFFSET,
  input wire POWER_DOWN,
  input wire AC_COUPLED,
  input wire [1:0] SIGNAL_CONFIG,
  input wire TRIPLE_CHANNEL,
  input wire OFFSET_RANGE_SYM,
  input wire BUFFER_TO_BLUE_TEST,
  input wire DATA_OUT_EN
);
  reg [3:0] ld_q;
  reg sc_q;
  reg [10:0] wd_q;
  // high three cycles after a load rise, when a commit may show
  wire cmt = ld_q[2] & ~ld_q[3];
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ld_q <= 4'hF;
      sc_q <= 1'b0;
      wd_q <= 11'h000;
    end else begin
      ld_q <= {ld_q[2:0], LOAD};
      sc_q <= SCLK;
      // own copy of the shifted word, msb first
      if (!LOAD && SCLK && !sc_q) wd_q <= {wd_q[9:0], SDATA};
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  AST_TRIPLE: assert property (TRIPLE_CHANNEL == SIGNAL_CONFIG[1])
    else $error("triple flag differs from config");
  AST_CFG_WORD: assert property (cmt && wd_q[10:8] == 3'h6 &&
    !wd_q[7] && !wd_q[6] |-> SIGNAL_CONFIG == wd_q[1:0] &&
    AC_COUPLED == wd_q[3])
    else $error("config differs from the last mode word");
  AST_PDN_CFG: assert property (POWER_DOWN |-> !AC_COUPLED && !SIGNAL_CONFIG)
    else $error("config kept in power down");
  AST_PDN_OE: assert property ($rose(POWER_DOWN) |-> !DATA_OUT_EN [*3])
    else $error("drivers on in power down");
  AST_OE_FELL: assert property ($fell(DATA_OUT_EN) |-> cmt)
    else $error("drivers off without a write");
  AST_MODE_CHG: assert property (!$stable({POWER_DOWN, SIGNAL_CONFIG}) |-> cmt)
    else $error("mode changed without a write");
  AST_TEST_CHG: assert property (!$stable({OFFSET_RANGE_SYM, BUFFER_TO_BLUE_TEST}) |-> cmt)
    else $error("test bits changed without a write");
  AST_GAIN_CHG: assert property (!$stable(RED_GAIN) |-> cmt)
    else $error("gain changed without a write");
  AST_OFS_CHG: assert property (!$stable(BLU_OFFSET) |-> cmt)
    else $error("offset changed without a write");
endmodule // afe_ctrl_bank_properties
bind afe_ctrl_bank afe_ctrl_bank_properties i_afe_ctrl_bank_properties (.*);

// [bench/afe_ctl_model.sv]
// scanner controller model that shifts serial words into the bank
`timescale 1ns/1ps
module afe_ctl_model (
  input wire CLK_SYS,
  output reg SCLK,
  output reg SDATA,
  output reg LOAD
);
  initial begin
    SCLK = 1'b0;
    SDATA = 1'b0;
    LOAD = 1'b1;
  end
  task send(input [10:0] w);
    integer i;
    begin
      @(posedge CLK_SYS) LOAD <= 1'b0;
      for (i = 10; i >= 0; i = i - 1) begin
        @(posedge CLK_SYS) SDATA <= w[i];
        SCLK <= 1'b0;
        @(posedge CLK_SYS) SCLK <= 1'b1;
        @(posedge CLK_SYS);
      end
      // released data line shows the inverse of its last bit
      @(posedge CLK_SYS) SCLK <= 1'b0;
      SDATA <= ~SDATA;
      @(posedge CLK_SYS) LOAD <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
    end
  endtask
endmodule // afe_ctl_model

// [bench/afe_ctrl_bank_tb.sv]
// self-checking bench for the afe control bank
`timescale 1ns/1ps
`include "afe_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fail_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module afe_ctrl_bank_tb;
  reg CLK_SYS;
  reg RST_N;
  wire SCLK, SDATA, LOAD, pd, tr, dr, ac, ip, tc, os, ce, bb, ae, cg, ft, rs, oe;
  wire [5:0] rg, gg, bg;
  wire [7:0] ro, go, bo;
  wire [1:0] sc;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int i;
  afe_ctl_model i_afe_ctl_model (.CLK_SYS(CLK_SYS), .SCLK(SCLK),
    .SDATA(SDATA), .LOAD(LOAD));
  afe_ctrl_bank i_afe_ctrl_bank (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .SCLK(SCLK), .SDATA(SDATA), .LOAD(LOAD), .RED_GAIN(rg), .GRN_GAIN(gg),
    .BLU_GAIN(bg), .RED_OFFSET(ro), .GRN_OFFSET(go), .BLU_OFFSET(bo),
    .POWER_DOWN(pd), .TOP_REFERENCE_SELECT(tr), .INPUT_DC_REFERENCE(dr),
    .AC_COUPLED(ac), .INVERTED_POLARITY(ip), .SIGNAL_CONFIG(sc),
    .TRIPLE_CHANNEL(tc), .OFFSET_RANGE_SYM(os), .CIS_REFERENCE_EN(ce),
    .BUFFER_TO_BLUE_TEST(bb), .AMP_TO_EXTREF_TEST(ae),
    .CONVERTER_FROM_GREEN_TEST(cg), .FIRST_TEST_ENABLE(ft),
    .RESERVED_TEST_BIT_HIGH(rs), .DATA_OUT_EN(oe));
  task wr(input [2:0] s, input [7:0] d);
    begin
      i_afe_ctl_model.send({s, d});
      #1;
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim;
    end
  end
  initial begin
    RST_N = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    #1;
    `CHK({ro, go, bo}, 24'h40_4040)
    `CHK({rg, gg, bg, oe}, 19'h0_0001)
    $display("test reset done");
    for (i = 0; i < 6; i++) wr(i[2:0], 8'hA4 + i * 8'h11);
    `CHK({rg, gg, bg}, 18'h2_9C7A)
    `CHK({ro, go, bo}, 24'hB5_D7F9)
    $display("test gain offset done");
    for (i = 0; i < 4; i++) begin
      wr(`AFE_SEL_MODE, 8'h3C | i);
      `CHK({tr, dr, ac, ip, sc, tc}, {4'hF, i[1:0], i[1]})
    end
    wr(`AFE_SEL_MODE, 8'h01);
    `CHK({tr, dr, ac, ip, sc, tc}, 7'h02)
    $display("test mode done");
    wr(`AFE_SEL_MODE_TEST, 8'h7F);
    `CHK({oe, os, ce, bb, ae, cg, ft, rs}, 8'h7E)
    wr(`AFE_SEL_MODE_TEST, 8'h00);
    `CHK({oe, os, ce, bb, ae, cg, ft, rs}, 8'h80)
    $display("test mode test done");
    wr(`AFE_SEL_MODE, 8'h8F);
    `CHK({pd, ac, sc, oe, ro}, 13'h10B5)
    wr(`AFE_SEL_MODE, 8'h0B);
    `CHK({pd, ac, sc, oe}, 5'h0F)
    $display("test power down done");
    wr(`AFE_SEL_MODE, 8'h4B);
    `CHK({ro, bg, sc, oe}, 17'h0_8001)
    $display("test soft reset done");
    end_sim;
  end
endmodule // afe_ctrl_bank_tb
